// ---- pkg/reclocker_status_map.svh ----
// Addresses, bit positions and reset values of the status and monitoring registers
`ifndef RECLOCKER_STATUS_MAP_SVH
`define RECLOCKER_STATUS_MAP_SVH

// ==========================================================
// Register addresses
`define RCK_ADDR_MASTER_RESET 8'h80
`define RCK_ADDR_LOSS_A 8'h83
`define RCK_ADDR_LOSS_B 8'h84
`define RCK_ADDR_ALARM_CLEAR 8'h85
`define RCK_ADDR_SUM_RESULT 8'h87
`define RCK_ADDR_LOCK_STATUS 8'h88
`define RCK_ADDR_RATE 8'h89

// ==========================================================
// Values
`define RCK_RESET_BYTE 8'h00
`define RCK_MASTER_RESET_KEY 8'haa
`define RCK_RATE_RESET 2'h0
`define RCK_CTRL_RESET 2'h0

// ==========================================================
// Bit positions
`define RCK_BIT_INPUT1_LOST 5
`define RCK_BIT_INPUT0_LOST 2
`define RCK_BIT_INPUT3_LOST 5
`define RCK_BIT_INPUT2_LOST 1
`define RCK_BIT_REF_MISSING 5
`define RCK_BIT_PLL_UNLOCKED 4
`define RCK_BIT_RECLOCKER_UNLOCKED 0
`define RCK_BIT_CLEAR_ALARMS 0
`define RCK_BIT_SOFT_RESET 1

// ==========================================================
// Alarm latch indices
`define RCK_ALARM_COUNT 7
`define RCK_IDX_INPUT0 0
`define RCK_IDX_INPUT1 1
`define RCK_IDX_INPUT2 2
`define RCK_IDX_INPUT3 3
`define RCK_IDX_REF_MISSING 4
`define RCK_IDX_PLL_UNLOCKED 5
`define RCK_IDX_RECLOCKER_UNLOCKED 6

`endif

// ---- pkg/reclocker_status_pkg.sv ----
// Types of the status and monitoring register group
`default_nettype none
package reclocker_status_pkg;

    typedef enum logic [1:0] {
        RATE_UNLOCKED,
        RATE_SD,
        RATE_HD,
        RATE_3G
    } rate_e;

    typedef struct packed {
        logic [7:0] master_reset;
        logic soft_reset;
        logic clear_alarms;
        logic [7:0] sum_result;
        logic [1:0] rate_meta;
        rate_e rate_sync;
        logic [7:0] rdata;
        logic master_pulse;
    } regs_state_s;

endpackage

`default_nettype wire

// ---- rtl/alarm_latch.sv ----
// Synchronised sticky alarm bits with a level clear
`timescale 1ns/1ps
`default_nettype none

module alarm_latch #(
    parameter int WIDTH = 7
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] raw_i,
    input wire logic clear_i,
    output logic [WIDTH-1:0] latched_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] sticky;
    } latch_state_s;

    latch_state_s state;
    latch_state_s next_state;

    // ==========================================================
    // Next state
    always_comb begin
        next_state = state;
        next_state.meta = raw_i;
        next_state.sync = state.meta;
        if (clear_i) begin
            next_state.sticky = '0;
        end else begin
            next_state.sticky = state.sticky | state.sync;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign latched_o = state.sticky;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_bits_stay_set: assert property (!clear_i |=> (state.sticky & $past(state.sticky)) == $past(state.sticky))
        else $error("latched alarm dropped without clear");
    a_relatch_after_clear: assert property ($fell(clear_i) && (state.sync != '0) |=> (state.sticky & $past(state.sync)) == $past(state.sync))
        else $error("present condition not relatched after clear");
    a_clear_empties: assert property (clear_i |=> state.sticky == '0)
        else $error("alarms not cleared while clear bit set");

endmodule

`default_nettype wire

// ---- rtl/reclocker_status_alarm_regs.sv ----
// Status, alarm clear, soft reset, checksum result and rate registers of the reclocker
//
// Notes on behaviour
// - Each input's loss bit latches at one until software clears it.
// - First loss register: input 1 in bit 5, input 0 in bit 2.
// - Second loss register: input 3 in bit 5, input 2 in bit 1.
// - While clear bit is one, all latched bits of both loss and lock registers clear.
// - Bit 1 of alarm clear register soft-resets only the recovery block.
// - Checksum result register shows all eight bits of the checksum outcome.
// - Lock status bit 5 reads one when the reference clock is absent.
// - Lock status bit 4 reads one when the reference PLL is unlocked.
// - Lock status bit 0 reads one when the reclocker lost lock.
// - Rate register low bits: 00 unlocked, 01 SD, 10 HD, 11 3G.
// - Writing AAh to master reset register resets the whole device; 00h normal.
`timescale 1ns/1ps
`default_nettype none
`include "reclocker_status_map.svh"

module reclocker_status_alarm_regs (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [3:0] input_signal_lost_i,
    input wire logic reference_clock_missing_i,
    input wire logic reference_pll_unlocked_i,
    input wire logic reclocker_unlocked_i,
    input wire logic [1:0] rate_detect_i,
    input wire logic [7:0] sum_result_i,
    input wire logic sum_valid_i,
    output logic recovery_block_soft_reset_o,
    output logic master_reset_o
);

    reclocker_status_pkg::regs_state_s state;
    reclocker_status_pkg::regs_state_s next_state;
    logic [`RCK_ALARM_COUNT-1:0] alarm_raw;
    logic [`RCK_ALARM_COUNT-1:0] alarms;

    // ==========================================================
    // Decoding
    function automatic logic is_mapped(input logic [7:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            `RCK_ADDR_MASTER_RESET,
            `RCK_ADDR_LOSS_A,
            `RCK_ADDR_LOSS_B,
            `RCK_ADDR_ALARM_CLEAR,
            `RCK_ADDR_SUM_RESULT,
            `RCK_ADDR_LOCK_STATUS,
            `RCK_ADDR_RATE: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    function automatic logic [7:0] read_byte(
        input logic [7:0] addr,
        input reclocker_status_pkg::regs_state_s s,
        input logic [`RCK_ALARM_COUNT-1:0] al
    );
        logic [7:0] v;
        v = `RCK_RESET_BYTE;
        case (addr)
            `RCK_ADDR_MASTER_RESET: begin
                v = s.master_reset;
            end
            `RCK_ADDR_LOSS_A: begin
                v[`RCK_BIT_INPUT1_LOST] = al[`RCK_IDX_INPUT1];
                v[`RCK_BIT_INPUT0_LOST] = al[`RCK_IDX_INPUT0];
            end
            `RCK_ADDR_LOSS_B: begin
                v[`RCK_BIT_INPUT3_LOST] = al[`RCK_IDX_INPUT3];
                v[`RCK_BIT_INPUT2_LOST] = al[`RCK_IDX_INPUT2];
            end
            `RCK_ADDR_ALARM_CLEAR: begin
                v[`RCK_BIT_SOFT_RESET] = s.soft_reset;
                v[`RCK_BIT_CLEAR_ALARMS] = s.clear_alarms;
            end
            `RCK_ADDR_SUM_RESULT: begin
                v = s.sum_result;
            end
            `RCK_ADDR_LOCK_STATUS: begin
                v[`RCK_BIT_REF_MISSING] = al[`RCK_IDX_REF_MISSING];
                v[`RCK_BIT_PLL_UNLOCKED] = al[`RCK_IDX_PLL_UNLOCKED];
                v[`RCK_BIT_RECLOCKER_UNLOCKED] = al[`RCK_IDX_RECLOCKER_UNLOCKED];
            end
            `RCK_ADDR_RATE: begin
                v[1:0] = s.rate_sync;
            end
            default: begin
                v = `RCK_RESET_BYTE;
            end
        endcase
        return v;
    endfunction

    // ==========================================================
    // Alarm latches
    assign alarm_raw = {
        reclocker_unlocked_i,
        reference_pll_unlocked_i,
        reference_clock_missing_i,
        input_signal_lost_i
    };

    alarm_latch #(
        .WIDTH(`RCK_ALARM_COUNT)
    ) u_alarm_latch (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .raw_i(alarm_raw),
        .clear_i(state.clear_alarms | state.master_pulse),
        .latched_o(alarms)
    );

    // ==========================================================
    // Register file
    always_comb begin
        next_state = state;
        next_state.master_pulse = 1'b0;
        next_state.rate_meta = rate_detect_i;
        next_state.rate_sync = reclocker_status_pkg::rate_e'(state.rate_meta);
        if (reg_wr_i) begin
            case (reg_addr_i)
                `RCK_ADDR_MASTER_RESET: begin
                    next_state.master_reset = reg_wdata_i;
                end
                `RCK_ADDR_ALARM_CLEAR: begin
                    next_state.soft_reset = reg_wdata_i[`RCK_BIT_SOFT_RESET];
                    next_state.clear_alarms = reg_wdata_i[`RCK_BIT_CLEAR_ALARMS];
                end
                `RCK_ADDR_SUM_RESULT: begin
                    next_state.sum_result = reg_wdata_i;
                end
                default: begin
                    next_state.master_reset = state.master_reset;
                end
            endcase
        end
        // Hardware result wins over a same-cycle software write
        if (sum_valid_i) begin
            next_state.sum_result = sum_result_i;
        end
        if (reg_rd_i) begin
            next_state.rdata = read_byte(reg_addr_i, state, alarms);
        end
        // Key written: one-cycle reset pulse, register file back to defaults
        if (reg_wr_i && reg_addr_i == `RCK_ADDR_MASTER_RESET && reg_wdata_i == `RCK_MASTER_RESET_KEY) begin
            next_state.master_pulse = 1'b1;
        end
        if (state.master_pulse) begin
            next_state.master_reset = `RCK_RESET_BYTE;
            next_state.soft_reset = 1'b0;
            next_state.clear_alarms = 1'b0;
            next_state.sum_result = `RCK_RESET_BYTE;
            next_state.rdata = `RCK_RESET_BYTE;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state.master_reset <= `RCK_RESET_BYTE;
            state.soft_reset <= 1'b0;
            state.clear_alarms <= 1'b0;
            state.sum_result <= `RCK_RESET_BYTE;
            state.rate_meta <= `RCK_RATE_RESET;
            state.rate_sync <= reclocker_status_pkg::RATE_UNLOCKED;
            state.rdata <= `RCK_RESET_BYTE;
            state.master_pulse <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata_o = state.rdata;
    assign recovery_block_soft_reset_o = state.soft_reset;
    assign master_reset_o = state.master_pulse;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_write_clear_one;
        reg_wr_i && reg_addr_i == `RCK_ADDR_ALARM_CLEAR && reg_wdata_i[`RCK_BIT_CLEAR_ALARMS] && !master_reset_o;
    endsequence

    sequence s_alarms_empty;
        alarms == '0;
    endsequence

    sequence s_key_write;
        reg_wr_i && reg_addr_i == `RCK_ADDR_MASTER_RESET && reg_wdata_i == `RCK_MASTER_RESET_KEY;
    endsequence

    a_clear_empties_all: assert property (s_write_clear_one |=> ##1 s_alarms_empty)
        else $error("write of clear bit did not empty alarms");
    a_master_pulse_once: assert property (s_key_write ##1 !(reg_wr_i && reg_addr_i == `RCK_ADDR_MASTER_RESET
        && reg_wdata_i == `RCK_MASTER_RESET_KEY) |-> master_reset_o ##1 !master_reset_o)
        else $error("master reset pulse not one cycle");
    a_master_restores: assert property (master_reset_o |=> state.master_reset == `RCK_RESET_BYTE
        && !recovery_block_soft_reset_o)
        else $error("registers not restored after master reset");
    a_soft_reset_hold: assert property (!(reg_wr_i && reg_addr_i == `RCK_ADDR_ALARM_CLEAR) && !master_reset_o
        |=> $stable(recovery_block_soft_reset_o))
        else $error("soft reset changed without a write");
    a_sum_loaded: assert property (sum_valid_i && !master_reset_o ##1 reg_rd_i && reg_addr_i == `RCK_ADDR_SUM_RESULT
        && !master_reset_o |=> reg_rdata_o == $past(sum_result_i, 2))
        else $error("checksum result not shown");
    a_rate_readback: assert property (reg_rd_i && reg_addr_i == `RCK_ADDR_RATE && !master_reset_o
        |=> reg_rdata_o == {6'h00, $past(state.rate_sync)})
        else $error("rate register read wrong");
    a_loss_a_layout: assert property (reg_rd_i && reg_addr_i == `RCK_ADDR_LOSS_A && !master_reset_o
        |=> reg_rdata_o == {2'h0, $past(alarms[`RCK_IDX_INPUT1]), 2'h0, $past(alarms[`RCK_IDX_INPUT0]), 2'h0})
        else $error("first loss register layout wrong");
    a_loss_b_layout: assert property (reg_rd_i && reg_addr_i == `RCK_ADDR_LOSS_B && !master_reset_o
        |=> reg_rdata_o == {2'h0, $past(alarms[`RCK_IDX_INPUT3]), 3'h0, $past(alarms[`RCK_IDX_INPUT2]), 1'h0})
        else $error("second loss register layout wrong");
    a_lock_layout: assert property (reg_rd_i && reg_addr_i == `RCK_ADDR_LOCK_STATUS && !master_reset_o
        |=> reg_rdata_o == {2'h0, $past(alarms[`RCK_IDX_REF_MISSING]), $past(alarms[`RCK_IDX_PLL_UNLOCKED]),
        3'h0, $past(alarms[`RCK_IDX_RECLOCKER_UNLOCKED])})
        else $error("lock status layout wrong");
    a_unmapped_zero: assert property (reg_rd_i && !is_mapped(reg_addr_i) |=> reg_rdata_o == `RCK_RESET_BYTE)
        else $error("unmapped read not zero");

endmodule

`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the reclocker status and alarm register group
`timescale 1ns/1ps
`default_nettype none
`include "reclocker_status_map.svh"

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [3:0] input_signal_lost_i = 4'h0;
    logic reference_clock_missing_i = 1'b0;
    logic reference_pll_unlocked_i = 1'b0;
    logic reclocker_unlocked_i = 1'b0;
    logic [1:0] rate_detect_i = 2'h0;
    logic [7:0] sum_result_i = 8'h00;
    logic sum_valid_i = 1'b0;
    logic recovery_block_soft_reset_o;
    logic master_reset_o;
    int mismatches = 0;
    int n_compared = 0;
    logic [7:0] rv;
    int pulses;

    reclocker_status_alarm_regs dut_u (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .input_signal_lost_i(input_signal_lost_i), .reference_clock_missing_i(reference_clock_missing_i),
        .reference_pll_unlocked_i(reference_pll_unlocked_i), .reclocker_unlocked_i(reclocker_unlocked_i),
        .rate_detect_i(rate_detect_i), .sum_result_i(sum_result_i), .sum_valid_i(sum_valid_i),
        .recovery_block_soft_reset_o(recovery_block_soft_reset_o), .master_reset_o(master_reset_o)
    );

    // ==========================================================
    // Clock and bus tasks
    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_i = 1'b0;
        d = reg_rdata_o;
    endtask

    // ==========================================================
    // Scenarios
    task automatic reset_values();
        rd(`RCK_ADDR_LOSS_A, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_LOSS_B, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_ALARM_CLEAR, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_SUM_RESULT, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_LOCK_STATUS, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_RATE, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_MASTER_RESET, rv); `CHK(rv, 8'h00)
        wr(`RCK_ADDR_LOSS_A, 8'hff);
        rd(`RCK_ADDR_LOSS_A, rv); `CHK(rv, 8'h00)
        rd(8'h86, rv); `CHK(rv, 8'h00)
    endtask

    task automatic sticky_alarms();
        input_signal_lost_i = 4'hf;
        reference_clock_missing_i = 1'b1;
        reference_pll_unlocked_i = 1'b1;
        reclocker_unlocked_i = 1'b1;
        idle(5);
        input_signal_lost_i = 4'h0;
        reference_clock_missing_i = 1'b0;
        reference_pll_unlocked_i = 1'b0;
        reclocker_unlocked_i = 1'b0;
        idle(5);
        rd(`RCK_ADDR_LOSS_A, rv); `CHK(rv, 8'h24)
        rd(`RCK_ADDR_LOSS_B, rv); `CHK(rv, 8'h22)
        rd(`RCK_ADDR_LOCK_STATUS, rv); `CHK(rv, 8'h31)
    endtask

    task automatic clear_and_relatch();
        input_signal_lost_i = 4'h9;
        idle(5);
        wr(`RCK_ADDR_ALARM_CLEAR, 8'h01);
        idle(2);
        rd(`RCK_ADDR_ALARM_CLEAR, rv); `CHK(rv, 8'h01)
        rd(`RCK_ADDR_LOSS_A, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_LOSS_B, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_LOCK_STATUS, rv); `CHK(rv, 8'h00)
        wr(`RCK_ADDR_ALARM_CLEAR, 8'h00);
        idle(3);
        rd(`RCK_ADDR_LOSS_A, rv); `CHK(rv, 8'h04)
        rd(`RCK_ADDR_LOSS_B, rv); `CHK(rv, 8'h20)
        input_signal_lost_i = 4'h0;
    endtask

    task automatic soft_reset_bit();
        wr(`RCK_ADDR_ALARM_CLEAR, 8'hfe);
        `CHK(recovery_block_soft_reset_o, 1'b1)
        rd(`RCK_ADDR_ALARM_CLEAR, rv); `CHK(rv, 8'h02)
        rd(`RCK_ADDR_LOSS_A, rv); `CHK(rv, 8'h04)
        wr(`RCK_ADDR_ALARM_CLEAR, 8'h00);
        `CHK(recovery_block_soft_reset_o, 1'b0)
    endtask

    task automatic checksum_result();
        @(negedge sys_clk_i);
        sum_result_i = 8'hc5;
        sum_valid_i = 1'b1;
        @(negedge sys_clk_i);
        sum_valid_i = 1'b0;
        sum_result_i = 8'h00;
        rd(`RCK_ADDR_SUM_RESULT, rv); `CHK(rv, 8'hc5)
        wr(`RCK_ADDR_SUM_RESULT, 8'h3a);
        rd(`RCK_ADDR_SUM_RESULT, rv); `CHK(rv, 8'h3a)
    endtask

    task automatic rate_codes();
        for (int r = 0; r < 4; r++) begin
            rate_detect_i = 2'(r);
            idle(4);
            rd(`RCK_ADDR_RATE, rv); `CHK(rv, {6'h00, 2'(r)})
        end
        rate_detect_i = 2'h0;
    endtask

    task automatic master_reset();
        wr(`RCK_ADDR_MASTER_RESET, 8'h55);
        rd(`RCK_ADDR_MASTER_RESET, rv); `CHK(rv, 8'h55)
        wr(`RCK_ADDR_ALARM_CLEAR, 8'h02);
        pulses = 0;
        @(negedge sys_clk_i);
        reg_addr_i = `RCK_ADDR_MASTER_RESET;
        reg_wdata_i = `RCK_MASTER_RESET_KEY;
        reg_wr_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk_i);
            reg_wr_i = 1'b0;
            if (master_reset_o === 1'b1) pulses++;
        end
        `CHK(pulses, 1)
        rd(`RCK_ADDR_MASTER_RESET, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_ALARM_CLEAR, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_SUM_RESULT, rv); `CHK(rv, 8'h00)
        rd(`RCK_ADDR_LOSS_A, rv); `CHK(rv, 8'h00)
        `CHK(recovery_block_soft_reset_o, 1'b0)
    endtask

    // ==========================================================
    // Verdict, watchdog and main sequence
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #100us;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        idle(12);
        rst_n_i = 1'b1;
        reset_values();
        sticky_alarms();
        clear_and_relatch();
        soft_reset_bit();
        checksum_result();
        rate_codes();
        master_reset();
        tally_and_finish();
    end
endmodule

`default_nettype wire
